// >>> src/ccx_pkg.sv
package ccx_pkg;
  // Register map of the plain register port
  localparam logic [3:0] CCX_OFF_CMD = 4'h0;
  localparam logic [3:0] CCX_OFF_SRC = 4'h1;
  localparam logic [3:0] CCX_OFF_STATUS = 4'h2;
  localparam logic [3:0] CCX_OFF_ACC_A_LO = 4'h3;
  localparam logic [3:0] CCX_OFF_ACC_A_HI = 4'h4;
  localparam logic [3:0] CCX_OFF_ACC_B_LO = 4'h5;
  localparam logic [3:0] CCX_OFF_ACC_B_HI = 4'h6;
  localparam logic [3:0] CCX_OFF_MONCTL = 4'h7;
  localparam logic [3:0] CCX_OFF_INFO = 4'h8;
  localparam logic [3:0] CCX_OFF_PTR = 4'h9;

  // Status word field positions
  localparam int CCX_SR_C = 0;
  localparam int CCX_SR_V = 1;
  localparam int CCX_SR_Z = 2;
  localparam int CCX_SR_N = 3;
  localparam int CCX_SR_U = 4;
  localparam int CCX_SR_E = 5;
  localparam int CCX_SR_L = 6;
  localparam int CCX_SR_SZ = 7;
  localparam logic [15:0] CCX_SR_RESET = 16'h0300;
  localparam logic [15:0] CCX_CC_MASK = 16'h00ff;

  // Monitor control inhibit bit
  localparam int CCX_MON_INHIBIT_BIT = 0;

  // Instruction timing in oscillator cycles
  localparam logic [3:0] CCX_CYC_REG = 4'h2;
  localparam logic [3:0] CCX_CYC_SHORT = 4'h4;
  localparam logic [3:0] CCX_CYC_LONG = 4'h6;
  localparam logic [3:0] CCX_CYC_MONITOR = 4'h4;
  localparam logic [3:0] CCX_CYC_PARALLEL = 4'h2;

  // Command field positions
  localparam int CCX_CMD_OP_LSB = 0;
  localparam int CCX_CMD_SRC_LSB = 4;
  localparam int CCX_CMD_DST_LSB = 8;
  localparam int CCX_CMD_PAR_BIT = 11;
  localparam int CCX_CMD_PRD_LSB = 12;
  localparam int CCX_CMD_LIM_BIT = 15;

  typedef enum logic [3:0] {
    CCX_OP_IDLE = 4'h0,
    CCX_OP_ZERO = 4'h1,
    CCX_OP_TEST = 4'h2,
    CCX_OP_MONITOR = 4'h3
  } ccx_op_t;

  // Operand selectors
  typedef enum logic [3:0] {
    CCX_SEL_A = 4'h0,
    CCX_SEL_B = 4'h1,
    CCX_SEL_XLO = 4'h2,
    CCX_SEL_YLO = 4'h3,
    CCX_SEL_YHI = 4'h4,
    CCX_SEL_AMID = 4'h5,
    CCX_SEL_BMID = 4'h6,
    CCX_SEL_PTR = 4'h7,
    CCX_SEL_MEM_SP = 4'h8,
    CCX_SEL_MEM_SHORT = 4'h9,
    CCX_SEL_MEM_LONG = 4'ha,
    CCX_SEL_IMM5 = 4'hb,
    CCX_SEL_IMM16 = 4'hc
  } ccx_sel_t;

  typedef enum logic [3:0] {
    CCX_ST_IDLE = 4'b0001,
    CCX_ST_BUSY = 4'b0010,
    CCX_ST_HALT = 4'b0100,
    CCX_ST_ERR = 4'b1000
  } ccx_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ccx_bus_req_t;

  typedef struct packed {
    ccx_state_t state;
    logic [3:0] cnt;
    logic [15:0] cmd;
    logic [35:0] acc_a;
    logic [35:0] acc_b;
    logic [15:0] xlo;
    logic [15:0] ylo;
    logic [15:0] yhi;
    logic [15:0] ptr;
    logic [15:0] src_word;
    logic [15:0] status;
    logic [15:0] monctl;
    logic [15:0] sr_pend;
    logic [1:0] words;
    logic dup_err;
    logic halted;
    logic busy;
    logic [15:0] rdata;
  } ccx_state_s_t;
endpackage

// >>> src/ccx_exec.sv
// Function
// - Accumulator clear zeros 36 bits, 2 cycles
// - Pointer clear is move zero, flags kept
// - Parallel-move form is one word, two cycles
// - Arithmetic and parallel read destinations differ
// - Clear takes two plus move cycles
// - Compare subtracts first from second, operands kept
// - Word versus accumulator: sign extend, pad zeros
// - Data register target: 16-bit middle-word subtract
// - N from bit 35, Z on zero
// - C from bit 35 carry, V on overflow
// - L on limit or overflow; E integer use
// - U when unnormalized; size flag from result bits 31:30
// - Register compare: 36-bit, 2 cycles, 1 word
// - Memory compare cycle and word counts
// - Short absolute operand is 6-bit address
// - Short immediate 0 to 31: 4 cycles
// - Signed 16-bit immediate: 6 cycles, 2 words
// - Monitor entry halts unless inhibit set
// - Inhibited monitor entry acts as two idles
// - Monitor entry: 4 cycles, flags unchanged
// - Accumulator clear sets U,Z; clears E,N,V
`timescale 1ns/1ps
module ccx_exec
  import ccx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] mem_rdata,
  input wire logic monitor_resume,
  output logic [15:0] reg_rdata,
  output logic [5:0] mem_addr,
  output logic busy,
  output logic halted,
  output logic [15:0] status_word
);

  ccx_state_s_t st_reg;
  ccx_state_s_t st_next;
  ccx_bus_req_t req;

  // 36-bit subtract result with carry and overflow
  typedef struct packed {
    logic [35:0] res;
    logic c;
    logic v;
  } ccx_sub_t;

  function automatic ccx_sub_t ccx_sub36(input logic [35:0] d, input logic [35:0] s);
    ccx_sub_t r;
    logic [36:0] w;
    w = {1'b0, d} - {1'b0, s};
    r.res = w[35:0];
    r.c = w[36];
    r.v = (d[35] ^ s[35]) & (d[35] ^ w[35]);
    return r;
  endfunction

  // Word widened for an accumulator target
  function automatic logic [35:0] ccx_widen(input logic [15:0] w);
    return {{4{w[15]}}, w, 16'h0000};
  endfunction

  // 16-bit word of the selected operand; accumulators give their middle word
  function automatic logic [15:0] ccx_word_of(input ccx_sel_t sel, input ccx_state_s_t s,
                                              input logic [15:0] mem);
    logic [15:0] w;
    w = 16'h0000;
    unique case (sel)
      CCX_SEL_A, CCX_SEL_AMID: w = s.acc_a[31:16];
      CCX_SEL_B, CCX_SEL_BMID: w = s.acc_b[31:16];
      CCX_SEL_XLO: w = s.xlo;
      CCX_SEL_YLO: w = s.ylo;
      CCX_SEL_YHI: w = s.yhi;
      CCX_SEL_PTR: w = s.ptr;
      CCX_SEL_MEM_SP, CCX_SEL_MEM_SHORT, CCX_SEL_MEM_LONG: w = mem;
      CCX_SEL_IMM5: w = {11'h000, s.src_word[4:0]};
      CCX_SEL_IMM16: w = s.src_word;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  always_comb begin
    req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  end

  // Decode, sequencing and flag computation
  always_comb begin
    ccx_op_t op;
    ccx_sel_t src;
    ccx_sel_t dst;
    ccx_sub_t sub;
    logic [35:0] d36;
    logic [35:0] s36;
    logic [15:0] sw;
    logic [15:0] dw;
    logic [15:0] cc;
    logic [3:0] cyc;
    logic [1:0] wrds;
    logic dst_acc;
    logic lim;
    logic [3:0] prd;
    op = ccx_op_t'(st_reg.cmd[CCX_CMD_OP_LSB +: 4]);
    src = ccx_sel_t'(st_reg.cmd[CCX_CMD_SRC_LSB +: 4]);
    dst = ccx_sel_t'({1'b0, st_reg.cmd[CCX_CMD_DST_LSB +: 3]});
    prd = st_reg.cmd[CCX_CMD_PRD_LSB +: 4];
    lim = st_reg.cmd[CCX_CMD_LIM_BIT];
    sub = '0;
    d36 = 36'h0;
    s36 = 36'h0;
    sw = 16'h0000;
    dw = 16'h0000;
    cc = st_reg.status;
    cyc = CCX_CYC_REG;
    wrds = 2'h1;
    dst_acc = (dst == CCX_SEL_A) || (dst == CCX_SEL_B);
    st_next = st_reg;
    st_next.rdata = 16'h0000;

    unique case (st_reg.state)
      CCX_ST_IDLE: begin
        if (req.wr && req.addr == CCX_OFF_CMD) begin
          st_next.cmd = req.wdata;
          st_next.state = CCX_ST_BUSY;
          st_next.dup_err = 1'b0;
          op = ccx_op_t'(req.wdata[CCX_CMD_OP_LSB +: 4]);
          src = ccx_sel_t'(req.wdata[CCX_CMD_SRC_LSB +: 4]);
          if (req.wdata[CCX_CMD_PAR_BIT] && op != CCX_OP_MONITOR &&
              req.wdata[CCX_CMD_PRD_LSB +: 3] == req.wdata[CCX_CMD_DST_LSB +: 3]) begin
            st_next.dup_err = 1'b1;
            st_next.state = CCX_ST_ERR;
          end
          if (op == CCX_OP_MONITOR) begin
            cyc = CCX_CYC_MONITOR;
          end else if (req.wdata[CCX_CMD_PAR_BIT]) begin
            cyc = CCX_CYC_PARALLEL;
          end else if (op == CCX_OP_TEST) begin
            unique case (src)
              CCX_SEL_MEM_SP: cyc = CCX_CYC_LONG;
              CCX_SEL_MEM_SHORT: cyc = CCX_CYC_SHORT;
              CCX_SEL_MEM_LONG: begin
                cyc = CCX_CYC_LONG;
                wrds = 2'h2;
              end
              CCX_SEL_IMM5: cyc = CCX_CYC_SHORT;
              CCX_SEL_IMM16: begin
                cyc = CCX_CYC_LONG;
                wrds = 2'h2;
              end
              default: cyc = CCX_CYC_REG;
            endcase
          end
          st_next.cnt = cyc - 4'h1;
          st_next.words = wrds;
          st_next.busy = 1'b1;
        end
      end
      CCX_ST_BUSY: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.state = CCX_ST_IDLE;
          st_next.busy = 1'b0;
          unique case (op)
            CCX_OP_ZERO: begin
              if (dst_acc) begin
                if (dst == CCX_SEL_A) st_next.acc_a = 36'h0;
                else st_next.acc_b = 36'h0;
                cc[CCX_SR_E] = 1'b0;
                cc[CCX_SR_N] = 1'b0;
                cc[CCX_SR_V] = 1'b0;
                cc[CCX_SR_U] = 1'b1;
                cc[CCX_SR_Z] = 1'b1;
                cc[CCX_SR_L] = lim;
              end else begin
                unique case (dst)
                  CCX_SEL_XLO: st_next.xlo = 16'h0000;
                  CCX_SEL_YLO: st_next.ylo = 16'h0000;
                  CCX_SEL_YHI: st_next.yhi = 16'h0000;
                  CCX_SEL_AMID: st_next.acc_a[31:16] = 16'h0000;
                  CCX_SEL_BMID: st_next.acc_b[31:16] = 16'h0000;
                  default: st_next.ptr = 16'h0000;
                endcase
              end
            end
            CCX_OP_TEST: begin
              sw = ccx_word_of(src, st_reg, mem_rdata);
              if (dst_acc) begin
                d36 = (dst == CCX_SEL_A) ? st_reg.acc_a : st_reg.acc_b;
                if (src == CCX_SEL_A) s36 = st_reg.acc_a;
                else if (src == CCX_SEL_B) s36 = st_reg.acc_b;
                else s36 = ccx_widen(sw);
              end else begin
                // 16-bit subtract in the middle field
                dw = ccx_word_of(dst, st_reg, mem_rdata);
                d36 = ccx_widen(dw);
                s36 = ccx_widen(sw);
              end
              sub = ccx_sub36(d36, s36);
              cc[CCX_SR_N] = sub.res[35];
              cc[CCX_SR_Z] = (sub.res == 36'h0);
              cc[CCX_SR_C] = sub.c;
              cc[CCX_SR_V] = sub.v;
              cc[CCX_SR_L] = lim | sub.v;
              cc[CCX_SR_E] = !((sub.res[35:31] == 5'h00) || (sub.res[35:31] == 5'h1f));
              cc[CCX_SR_U] = (sub.res[31] == sub.res[30]);
              cc[CCX_SR_SZ] = (sub.res[31:30] == 2'b01) || (sub.res[31:30] == 2'b10);
            end
            CCX_OP_MONITOR: begin
              if (!st_reg.monctl[CCX_MON_INHIBIT_BIT]) begin
                st_next.state = CCX_ST_HALT;
                st_next.halted = 1'b1;
              end
              // otherwise falls through as two idles
            end
            default: ;
          endcase
          // flags committed at the last cycle
          st_next.status = cc;
        end
      end
      CCX_ST_HALT: begin
        if (monitor_resume) begin
          st_next.state = CCX_ST_IDLE;
          st_next.halted = 1'b0;
        end
      end
      CCX_ST_ERR: begin
        // Refused command leaves state untouched but keeps busy for its slot
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.state = CCX_ST_IDLE;
          st_next.busy = 1'b0;
        end
      end
    endcase

    // Software register writes only while idle; monitor control at any time
    if (req.wr && st_reg.state == CCX_ST_IDLE) begin
      unique case (req.addr)
        CCX_OFF_SRC: st_next.src_word = req.wdata;
        CCX_OFF_STATUS: st_next.status = req.wdata;
        CCX_OFF_ACC_A_LO: st_next.acc_a[15:0] = req.wdata;
        CCX_OFF_ACC_A_HI: st_next.acc_a[35:16] = {req.wdata[15], req.wdata[15],
                                                  req.wdata[15], req.wdata[15], req.wdata};
        CCX_OFF_ACC_B_LO: st_next.acc_b[15:0] = req.wdata;
        CCX_OFF_ACC_B_HI: st_next.acc_b[35:16] = {req.wdata[15], req.wdata[15],
                                                  req.wdata[15], req.wdata[15], req.wdata};
        CCX_OFF_MONCTL: st_next.monctl = req.wdata;
        CCX_OFF_PTR: st_next.ptr = req.wdata;
        default: ;
      endcase
    end
    if (req.wr && req.addr == CCX_OFF_MONCTL && st_reg.state != CCX_ST_IDLE) begin
      st_next.monctl = req.wdata;
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    if (req.rd) begin
      unique case (req.addr)
        CCX_OFF_CMD: st_next.rdata = st_reg.cmd;
        CCX_OFF_SRC: st_next.rdata = st_reg.src_word;
        CCX_OFF_STATUS: st_next.rdata = st_reg.status;
        CCX_OFF_ACC_A_LO: st_next.rdata = st_reg.acc_a[15:0];
        CCX_OFF_ACC_A_HI: st_next.rdata = st_reg.acc_a[31:16];
        CCX_OFF_ACC_B_LO: st_next.rdata = st_reg.acc_b[15:0];
        CCX_OFF_ACC_B_HI: st_next.rdata = st_reg.acc_b[31:16];
        CCX_OFF_MONCTL: st_next.rdata = st_reg.monctl;
        CCX_OFF_INFO: st_next.rdata = {8'h00, st_reg.acc_b[35:32], st_reg.acc_a[35:32]} |
                                      {st_reg.dup_err, st_reg.halted, st_reg.busy,
                                       3'b000, st_reg.words, 8'h00};
        CCX_OFF_PTR: st_next.rdata = st_reg.ptr;
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.state <= CCX_ST_IDLE;
      st_reg.status <= CCX_SR_RESET;
      st_reg.words <= 2'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops; short address from source word
  always_comb begin
    reg_rdata = st_reg.rdata;
    mem_addr = st_reg.src_word[5:0];
    busy = st_reg.busy;
    halted = st_reg.halted;
    status_word = st_reg.status;
  end

endmodule // ccx_exec

// >>> dv/ccx_exec_checker.sv
`timescale 1ns/1ps
module ccx_exec_checker
  import ccx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] mem_rdata,
  input wire logic monitor_resume,
  input wire logic [15:0] reg_rdata,
  input wire logic [5:0] mem_addr,
  input wire logic busy,
  input wire logic halted,
  input wire logic [15:0] status_word
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic go, alu, par, dup, inh_reg;
  logic [3:0] op, src;
  // Command taken by an idle core, and its fields
  assign go = reg_wr && reg_addr == CCX_OFF_CMD && !busy && !halted;
  assign op = reg_wdata[3:0];
  assign src = reg_wdata[7:4];
  assign alu = op == CCX_OP_ZERO || op == CCX_OP_TEST;
  assign par = reg_wdata[11];
  assign dup = par && reg_wdata[14:12] == reg_wdata[10:8];
  // Inhibit shadow; monitor control is writable even while busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inh_reg <= 1'b0;
    end else if (reg_wr && reg_addr == CCX_OFF_MONCTL) begin
      inh_reg <= reg_wdata[0];
    end
  end
  property p_clr_acc;
    go && op == CCX_OP_ZERO && !par && reg_wdata[10:9] == 2'b00 |=>
      busy [*2] ##1 !busy && status_word[5:1] == 5'h0a;
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("acc clear wrong");
  property p_clr_ptr;
    go && op == CCX_OP_ZERO && !par && reg_wdata[10:8] == 3'h7 |=> $stable(status_word) [*3];
  endproperty
  a_clr_ptr: assert property (p_clr_ptr) else $error("ptr clear moved flags");
  property p_par;
    go && alu && par && !dup |=> busy [*2] ##1 !busy;
  endproperty
  a_par: assert property (p_par) else $error("parallel form timing");
  property p_dup;
    go && alu && dup |=> (busy && $stable(status_word)) [*2] ##1 !busy && $stable(status_word);
  endproperty
  a_dup: assert property (p_dup) else $error("clash not refused");
  property p_cmp4;
    go && op == CCX_OP_TEST && !par && (src == CCX_SEL_MEM_SHORT || src == CCX_SEL_IMM5) |=>
      busy [*4] ##1 !busy;
  endproperty
  a_cmp4: assert property (p_cmp4) else $error("short compare timing");
  property p_cmp6;
    go && op == CCX_OP_TEST && !par && (src == CCX_SEL_MEM_SP || src == CCX_SEL_MEM_LONG ||
      src == CCX_SEL_IMM16) |=> busy [*6] ##1 !busy;
  endproperty
  a_cmp6: assert property (p_cmp6) else $error("long compare timing");
  property p_mon_halt;
    go && op == CCX_OP_MONITOR && !inh_reg |-> ##[1:6] halted;
  endproperty
  a_mon_halt: assert property (p_mon_halt) else $error("no halt");
  property p_mon_inh;
    go && op == CCX_OP_MONITOR && inh_reg |=>
      (busy && !halted && $stable(status_word)) [*4] ##1 !busy && !halted;
  endproperty
  a_mon_inh: assert property (p_mon_inh) else $error("inhibited entry wrong");
  c_clr: cover property (go && op == CCX_OP_ZERO);
  c_dup: cover property (go && alu && dup);
  c_halt: cover property (go && op == CCX_OP_MONITOR && !inh_reg);
endmodule  // ccx_exec_checker

bind ccx_exec ccx_exec_checker i_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_rdata(mem_rdata), .monitor_resume(monitor_resume),
  .reg_rdata(reg_rdata), .mem_addr(mem_addr), .busy(busy), .halted(halted),
  .status_word(status_word)
);

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb
  import ccx_pkg::*;
;
  logic clk, sys_rst, reg_wr, reg_rd, monitor_resume, busy, halted;
  logic [3:0] reg_addr, s;
  logic [15:0] reg_wdata, mem_rdata, reg_rdata, status_word, d, sw, m, prev;
  logic [5:0] mem_addr;
  logic [31:0] seed, a, b;
  logic [35:0] dv, sv;
  int failures, num_checks, n, k;
  logic [3:0] sels [9] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  int cyc [9] = '{2, 2, 2, 2, 6, 4, 6, 4, 6};

  ccx_exec i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_rdata(mem_rdata), .monitor_resume(monitor_resume),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .busy(busy), .halted(halted),
    .status_word(status_word)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Word operand: sign extend, zero fill below
  function automatic logic [35:0] ext(logic [15:0] w);
    return {{4{w[15]}}, w, 16'h0000};
  endfunction
  // Expected E,U,N,Z,V,C of x minus y
  function automatic logic [5:0] flags(logic [35:0] x, logic [35:0] y);
    logic [36:0] r;
    r = {1'b0, x} - {1'b0, y};
    return {r[35:31] != {5{r[35]}}, r[31] == r[30], r[35], r[35:0] == 36'h0,
      x[35] != y[35] && r[35] != x[35], r[36]};
  endfunction
  // Low bit of p is the parallel bit, upper three the read destination
  function automatic logic [15:0] cmd(logic [3:0] op, logic [3:0] sr, logic [2:0] ds,
    logic [3:0] p);
    return {1'b0, p, ds, sr, op};
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] ad, logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] ad);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Extension follows the sign of the high half
  task automatic seta(logic [3:0] lo, logic [31:0] v);
    wr(lo, v[15:0]);
    wr(lo + 4'h1, v[31:16]);
  endtask
  // Issue a command and count the cycles that busy stands
  task automatic run(logic [15:0] c);
    wr(CCX_OFF_CMD, c);
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog: the sequence needs some 1000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    seed = 32'hea3d4c75;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, monitor_resume} = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    mem_rdata = 16'h0000;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CCX_OFF_STATUS);
    chk("status rst", CCX_SR_RESET, d);
    rd(4'hf);
    chk("unmapped", 16'h0000, d);
    // Clear each accumulator, then the pointer
    for (int t = 0; t < 2; t++) begin
      seta(t ? CCX_OFF_ACC_B_LO : CCX_OFF_ACC_A_LO, rnd() | 32'h1);
      run(cmd(4'h1, 4'h0, 3'(t), 4'h0));
      chk("clr cyc", 16'h0002, 16'(n));
      chk("clr cc", 16'h000a, {11'h000, status_word[5:1]});
      rd(t ? CCX_OFF_ACC_B_HI : CCX_OFF_ACC_A_HI);
      chk("clr acc", 16'h0000, d);
    end
    wr(CCX_OFF_PTR, 16'h5a5a);
    prev = status_word;
    run(cmd(4'h1, 4'h0, 3'h7, 4'h0));
    chk("ptr cc", prev, status_word);
    rd(CCX_OFF_PTR);
    chk("ptr", 16'h0000, d);
    // Random compares over nine operand forms; the first has equal operands
    for (int i = 0; i < 40; i++) begin
      a = rnd();
      b = (i == 0) ? a : rnd();
      k = (i == 0) ? 1 : int'(rnd() % 9);
      s = sels[k];
      sw = (s == 4'hb) ? 16'(rnd() % 32) : 16'(rnd());
      m = 16'(rnd());
      seta(CCX_OFF_ACC_A_LO, a);
      seta(CCX_OFF_ACC_B_LO, b);
      wr(CCX_OFF_SRC, sw);
      @(posedge clk);
      mem_rdata <= m;
      dv = i[0] ? {{4{b[31]}}, b} : {{4{a[31]}}, a};
      case (s)
        4'h0: sv = {{4{a[31]}}, a};
        4'h1: sv = {{4{b[31]}}, b};
        4'h5: sv = ext(a[31:16]);
        4'h6: sv = ext(b[31:16]);
        4'hb: sv = ext(sw);
        4'hc: sv = ext(sw);
        default: sv = ext(m);
      endcase
      run(cmd(4'h2, s, {2'b00, i[0]}, 4'h0));
      chk("cmp cyc", 16'(cyc[k]), 16'(n));
      chk("cmp cc", {8'h03, 2'b00, flags(dv, sv)},
        {status_word[15:8], 2'b00, status_word[5:0]});
      chk("mem addr", {10'h000, sw[5:0]}, {10'h000, mem_addr});
      rd(CCX_OFF_ACC_A_HI);
      chk("keep A", a[31:16], d);
      rd(CCX_OFF_ACC_B_LO);
      chk("keep B", b[15:0], d);
    end
    // Parallel forms, then a clash of destinations
    run(cmd(4'h2, 4'h0, 3'h1, 4'h5));
    chk("par cmp cyc", 16'h0002, 16'(n));
    run(cmd(4'h1, 4'h0, 3'h0, 4'h7));
    chk("par clr cyc", 16'h0002, 16'(n));
    prev = status_word;
    run(cmd(4'h2, 4'h0, 3'h1, 4'h3));
    chk("dup cc", prev, status_word);
    rd(CCX_OFF_INFO);
    chk("dup err", 16'h0001, {15'h0000, d[15]});
    // Inhibited entry acts as two idles; then a real halt and resume
    wr(CCX_OFF_MONCTL, 16'h0001);
    run(cmd(4'h3, 4'h0, 3'h0, 4'h0));
    chk("mon cyc", 16'h0004, 16'(n));
    chk("mon inh", 16'h0000, 16'(halted));
    chk("mon cc", prev, status_word);
    wr(CCX_OFF_MONCTL, 16'h0000);
    run(cmd(4'h3, 4'h0, 3'h0, 4'h0));
    for (k = 0; k < 8 && halted !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("halted", 16'h0001, 16'(halted));
    wr(CCX_OFF_CMD, cmd(4'h1, 4'h0, 3'h0, 4'h0));
    chk("halt busy", 16'h0000, 16'(busy));
    @(posedge clk);
    monitor_resume <= 1'b1;
    @(posedge clk);
    monitor_resume <= 1'b0;
    #1;
    chk("resumed", 16'h0000, 16'(halted));
    test_done();
  end
endmodule  // tb
